/* design/pulse_pattern_output.sv */
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module pulse_pattern_output #(
	parameter int unsigned CHANNELS = 4
) (
	input  wire logic                                 clk_i,
	input  wire logic                                 arst_n_i,
	input  wire logic                                 ce_i,
	input  wire pulse_pattern_pkg::apb_req_type       apb_i,
	output pulse_pattern_pkg::apb_rsp_type            apb_o,
	input  wire logic [CHANNELS-1:0]                  cmp_match_i,
	output logic      [15:0]                          pattern_output_pin_o,
	output logic      [15:0]                          pattern_enable_bits_o
);
	import pulse_pattern_pkg::*;

	if (CHANNELS != GROUPS) begin : g_bad_channels
		$error("CHANNELS must equal the four trigger codes");
	end

	core_state_type state;
	core_state_type next_state;
	logic [7:0]     rd_data;
	logic           rd_hit;
	logic           wr_en;
	logic [GROUPS-1:0] fire;
	logic [15:0]    level;
	logic           shared_upper;
	logic           shared_lower;

	apb_byte_slave u_slave (
		.clk_i     (clk_i),
		.arst_n_i  (arst_n_i),
		.ce_i      (ce_i),
		.apb_i     (apb_i),
		.rd_data_i (rd_data),
		.rd_hit_i  (rd_hit),
		.apb_o     (apb_o),
		.wr_en_o   (wr_en)
	);

	for (genvar g = 0; g < GROUPS; g++) begin : g_group
		pattern_group u_group (
			.trigger_code_i (state.trigger_select_register[TRIG_W*g +: TRIG_W]),
			.cmp_match_i    (cmp_match_i),
			.polarity_i     (state.output_mode_register[MODE_POLARITY_LSB + g]),
			.stored_i       (state.pattern_data[GROUP_W*g +: GROUP_W]),
			.fire_o         (fire[g]),
			.level_o        (level[GROUP_W*g +: GROUP_W])
		);
	end

	// Groups 3/2 and 1/0 share a trigger when their codes match
	always_comb begin
		shared_upper = state.trigger_select_register[7:6] == state.trigger_select_register[5:4];
		shared_lower = state.trigger_select_register[3:2] == state.trigger_select_register[1:0];
	end

	// Read decode, settled during the setup cycle
	always_comb begin
		rd_hit = 1'b1;
		rd_data = 8'h00;
		unique case (apb_i.paddr)
			reg_addr(IDX_TRIGGER_SELECT): rd_data = state.trigger_select_register;
			reg_addr(IDX_OUTPUT_MODE): rd_data = state.output_mode_register;
			reg_addr(IDX_ENABLE_UPPER): rd_data = state.pattern_enable_bits[15:8];
			reg_addr(IDX_ENABLE_LOWER): rd_data = state.pattern_enable_bits[7:0];
			reg_addr(IDX_DATA_UPPER): rd_data = state.pattern_data[15:8];
			reg_addr(IDX_DATA_LOWER): rd_data = state.pattern_data[7:0];
			reg_addr(IDX_NEXT_UPPER): begin
				rd_data = next_read(shared_upper, 1'b1, state.pending_pattern[15:8]);
			end
			reg_addr(IDX_NEXT_UPPER_ALT): begin
				rd_data = next_read(shared_upper, 1'b0, state.pending_pattern[15:8]);
			end
			reg_addr(IDX_NEXT_LOWER): begin
				rd_data = next_read(shared_lower, 1'b1, state.pending_pattern[7:0]);
			end
			reg_addr(IDX_NEXT_LOWER_ALT): begin
				rd_data = next_read(shared_lower, 1'b0, state.pending_pattern[7:0]);
			end
			default: rd_hit = 1'b0;
		endcase
	end

	always_comb begin
		logic [7:0]  wbyte;
		logic [7:0]  mask;
		logic [15:0] en;
		wbyte = apb_i.pwdata[7:0];
		mask = 8'h00;
		next_state = state;
		en = state.pattern_enable_bits;
		if (wr_en) begin
			unique case (apb_i.paddr)
				reg_addr(IDX_TRIGGER_SELECT): next_state.trigger_select_register = wbyte;
				reg_addr(IDX_OUTPUT_MODE): next_state.output_mode_register = wbyte;
				reg_addr(IDX_ENABLE_UPPER): next_state.pattern_enable_bits[15:8] = wbyte;
				reg_addr(IDX_ENABLE_LOWER): next_state.pattern_enable_bits[7:0] = wbyte;
				reg_addr(IDX_DATA_UPPER): begin
					// Enabled bits belong to the generator, not software
					next_state.pattern_data[15:8] =
						(state.pattern_data[15:8] & en[15:8]) | (wbyte & ~en[15:8]);
				end
				reg_addr(IDX_DATA_LOWER): begin
					next_state.pattern_data[7:0] =
						(state.pattern_data[7:0] & en[7:0]) | (wbyte & ~en[7:0]);
				end
				reg_addr(IDX_NEXT_UPPER): begin
					mask = next_wmask(shared_upper, 1'b1);
					next_state.pending_pattern[15:8] =
						(state.pending_pattern[15:8] & ~mask) | (wbyte & mask);
				end
				reg_addr(IDX_NEXT_UPPER_ALT): begin
					mask = next_wmask(shared_upper, 1'b0);
					next_state.pending_pattern[15:8] =
						(state.pending_pattern[15:8] & ~mask) | (wbyte & mask);
				end
				reg_addr(IDX_NEXT_LOWER): begin
					mask = next_wmask(shared_lower, 1'b1);
					next_state.pending_pattern[7:0] =
						(state.pending_pattern[7:0] & ~mask) | (wbyte & mask);
				end
				reg_addr(IDX_NEXT_LOWER_ALT): begin
					mask = next_wmask(shared_lower, 1'b0);
					next_state.pending_pattern[7:0] =
						(state.pending_pattern[7:0] & ~mask) | (wbyte & mask);
				end
				default: begin
				end
			endcase
		end
		// Trigger load touches only enabled bits, which software cannot write,
		// so the two never collide on one bit
		for (int g = 0; g < GROUPS; g++) begin
			if (fire[g]) begin
				next_state.pattern_data[GROUP_W*g +: GROUP_W] =
					(state.pending_pattern[GROUP_W*g +: GROUP_W] & en[GROUP_W*g +: GROUP_W]) |
					(next_state.pattern_data[GROUP_W*g +: GROUP_W] &
					~en[GROUP_W*g +: GROUP_W]);
			end
		end
		next_state.pins = level;
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state.trigger_select_register <= RST_TRIGGER_SELECT;
			state.output_mode_register <= RST_OUTPUT_MODE;
			state.pattern_enable_bits <= {RST_ENABLE, RST_ENABLE};
			state.pattern_data <= {RST_DATA, RST_DATA};
			state.pending_pattern <= {RST_NEXT, RST_NEXT};
			// Pins idle at the level a zero store gives under direct polarity
			state.pins <= 16'h0000;
		end else if (ce_i) begin
			state <= next_state;
		end
	end

	always_comb begin
		pattern_output_pin_o = state.pins;
		pattern_enable_bits_o = state.pattern_enable_bits;
	end

endmodule
`default_nettype wire

/* design/pulse_pattern_pkg.sv */
package pulse_pattern_pkg;

	localparam int unsigned GROUPS = 4;
	localparam int unsigned GROUP_W = 4;
	localparam int unsigned TRIG_W = 2;

	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_TRIGGER_SELECT = 16'hff46;
	localparam logic [15:0] IDX_OUTPUT_MODE = 16'hff47;
	localparam logic [15:0] IDX_ENABLE_UPPER = 16'hff48;
	localparam logic [15:0] IDX_ENABLE_LOWER = 16'hff49;
	localparam logic [15:0] IDX_DATA_UPPER = 16'hff4a;
	localparam logic [15:0] IDX_DATA_LOWER = 16'hff4b;
	localparam logic [15:0] IDX_NEXT_UPPER = 16'hff4c;
	localparam logic [15:0] IDX_NEXT_LOWER = 16'hff4d;
	localparam logic [15:0] IDX_NEXT_UPPER_ALT = 16'hff4e;
	localparam logic [15:0] IDX_NEXT_LOWER_ALT = 16'hff4f;

	localparam logic [7:0] RST_TRIGGER_SELECT = 8'h00;
	localparam logic [7:0] RST_OUTPUT_MODE = 8'hf0;
	localparam logic [7:0] RST_ENABLE = 8'h00;
	localparam logic [7:0] RST_DATA = 8'h00;
	localparam logic [7:0] RST_NEXT = 8'h00;
	localparam logic [3:0] RESERVED_NIBBLE = 4'hf;
	localparam int unsigned MODE_POLARITY_LSB = 4;
	localparam int unsigned MODE_NONOVERLAP_LSB = 0;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] paddr;
		logic [31:0] pwdata;
	} apb_req_type;

	typedef struct packed {
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} apb_rsp_type;

	typedef struct packed {
		logic [7:0]  trigger_select_register;
		logic [7:0]  output_mode_register;
		logic [15:0] pattern_enable_bits;
		logic [15:0] pattern_data;
		logic [15:0] pending_pattern;
		logic [15:0] pins;
	} core_state_type;

	function automatic logic [31:0] reg_addr(input logic [15:0] idx);
		reg_addr = {14'h0000, idx, 2'b00};
	endfunction

	// Read view of one next-data byte; primary is the FF4C/FF4D address
	function automatic logic [7:0] next_read(input logic shared, input logic primary,
		input logic [7:0] nd);
		if (shared) begin
			next_read = primary ? nd : 8'hff;
		end else if (primary) begin
			next_read = {nd[7:4], RESERVED_NIBBLE};
		end else begin
			next_read = {RESERVED_NIBBLE, nd[3:0]};
		end
	endfunction

	// Bits of a next-data byte that a write may change
	function automatic logic [7:0] next_wmask(input logic shared, input logic primary);
		if (shared) begin
			next_wmask = primary ? 8'hff : 8'h00;
		end else begin
			next_wmask = primary ? 8'hf0 : 8'h0f;
		end
	endfunction

endpackage

/* design/pattern_group.sv */
`timescale 1ns/1ps
`default_nettype none
module pattern_group (
	input  wire logic [pulse_pattern_pkg::TRIG_W-1:0]  trigger_code_i,
	input  wire logic [pulse_pattern_pkg::GROUPS-1:0]  cmp_match_i,
	input  wire logic                                  polarity_i,
	input  wire logic [pulse_pattern_pkg::GROUP_W-1:0] stored_i,
	output logic                                       fire_o,
	output logic      [pulse_pattern_pkg::GROUP_W-1:0] level_o
);
	import pulse_pattern_pkg::*;

	always_comb begin
		fire_o = cmp_match_i[trigger_code_i];
		level_o = polarity_i ? stored_i : ~stored_i;
	end

endmodule
`default_nettype wire

/* design/apb_byte_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module apb_byte_slave (
	input  wire logic                           clk_i,
	input  wire logic                           arst_n_i,
	input  wire logic                           ce_i,
	input  wire pulse_pattern_pkg::apb_req_type apb_i,
	input  wire logic [7:0]                     rd_data_i,
	input  wire logic                           rd_hit_i,
	output pulse_pattern_pkg::apb_rsp_type      apb_o,
	output logic                                wr_en_o
);
	import pulse_pattern_pkg::*;

	typedef struct packed {
		logic [7:0] rdata;
		logic       err;
	} slave_state_type;

	slave_state_type state;
	slave_state_type next_state;
	logic            access;

	// Read data is caught in the setup cycle so prdata comes from a flop
	always_comb begin
		next_state = state;
		access = apb_i.psel & apb_i.penable & ce_i;
		if (apb_i.psel & ~apb_i.penable) begin
			next_state.rdata = apb_i.pwrite ? 8'h00 : rd_data_i;
			next_state.err = ~rd_hit_i;
		end
		wr_en_o = access & apb_i.pwrite & ~state.err;
		apb_o.pready = access;
		apb_o.prdata = {24'h000000, state.rdata};
		apb_o.pslverr = access & state.err;
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= '0;
		end else if (ce_i) begin
			state <= next_state;
		end
	end

endmodule
`default_nettype wire

/* verification/pulse_pattern_output_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module pulse_pattern_output_sva #(
	parameter int unsigned CHANNELS = 4
) (
	input wire logic				clk_i,
	input wire logic				arst_n_i,
	input wire logic				ce_i,
	input wire pulse_pattern_pkg::apb_req_type	apb_i,
	input wire pulse_pattern_pkg::apb_rsp_type	apb_o,
	input wire logic [CHANNELS-1:0]			cmp_match_i,
	input wire logic [15:0]				pattern_output_pin_o,
	input wire logic [15:0]				pattern_enable_bits_o
);
	import pulse_pattern_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	logic	acc;
	logic	cause;
	assign acc = apb_i.psel && apb_i.penable && ce_i;
	// Pins may trail a write or a match by one extra cycle
	assign cause = (acc && apb_i.pwrite) || (|cmp_match_i);
	sequence s_hit(logic [15:0] idx, logic w);
		acc && apb_i.pwrite == w && apb_i.paddr == {14'h0, idx, 2'b00};
	endsequence
	chk_ready_zero_wait: assert property (acc |-> apb_o.pready)
		else $error("pready missing in access");
	chk_ready_idle: assert property (!acc |-> !apb_o.pready)
		else $error("pready outside access");
	chk_err_in_access: assert property (apb_o.pslverr |-> acc)
		else $error("pslverr outside access");
	chk_rdata_upper: assert property (apb_o.prdata[31:8] == 24'h0)
		else $error("prdata upper bits set");
	chk_enable_low_write: assert property (s_hit(IDX_ENABLE_LOWER, 1'b1)
		|=> pattern_enable_bits_o[7:0] == $past(apb_i.pwdata[7:0])) else $error("lower enable");
	chk_enable_high_write: assert property (s_hit(IDX_ENABLE_UPPER, 1'b1)
		|=> pattern_enable_bits_o[15:8] == $past(apb_i.pwdata[7:0])) else $error("upper enable");
	chk_enable_by_write: assert property ($changed(pattern_enable_bits_o) |-> $past(acc))
		else $error("enable changed without write");
	chk_enable_readback: assert property (s_hit(IDX_ENABLE_LOWER, 1'b0)
		|-> apb_o.prdata[7:0] == pattern_enable_bits_o[7:0]) else $error("enable readback");
	chk_pin_cause: assert property ($changed(pattern_output_pin_o)
		|-> $past(cause) || $past(cause, 2)) else $error("pins changed without cause");
	chk_freeze_ce: assert property (!ce_i |=> $stable(pattern_output_pin_o))
		else $error("pins moved while frozen");
endmodule
bind pulse_pattern_output pulse_pattern_output_sva #(.CHANNELS(CHANNELS)) i_sva (.clk_i(clk_i),
	.arst_n_i(arst_n_i), .ce_i(ce_i), .apb_i(apb_i), .apb_o(apb_o), .cmp_match_i(cmp_match_i),
	.pattern_output_pin_o(pattern_output_pin_o), .pattern_enable_bits_o(pattern_enable_bits_o));
`default_nettype wire

/* verification/timer_match_model.sv */
`timescale 1ns/1ps
`default_nettype none
module timer_match_model (
	input wire logic	clk_i,
	input wire logic	arst_n_i,
	input wire logic [3:0]	fire_i,
	input wire logic [3:0]	lag_i,
	output logic [3:0]	cmp_match_o
);
	logic [3:0]	cnt;
	logic [3:0]	ch;
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt <= '0;
			ch <= '0;
			cmp_match_o <= '0;
		end else begin
			cmp_match_o <= '0;
			if (|fire_i) begin
				ch <= fire_i;
				cnt <= lag_i;
			end else if (cnt != 0) begin
				cnt <= cnt - 4'd1;
			end else if (|ch) begin
				cmp_match_o <= ch;
				ch <= '0;
			end
		end
	end
endmodule
`default_nettype wire

/* verification/pulse_pattern_output_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module pulse_pattern_output_tb_top;
	import pulse_pattern_pkg::*;
	logic		clk_i;
	logic		arst_n_i;
	logic		ce_i;
	apb_req_type	req;
	apb_rsp_type	rsp;
	logic [3:0]	fire;
	logic [3:0]	lag;
	logic [3:0]	cm;
	logic [15:0]	pins;
	logic [15:0]	en;
	logic [7:0]	q;
	logic [7:0]	v;
	logic		e;
	int		n_fail;
	int		check_count;
	pulse_pattern_output #(.CHANNELS(4)) i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
		.apb_i(req), .apb_o(rsp), .cmp_match_i(cm), .pattern_output_pin_o(pins),
		.pattern_enable_bits_o(en));
	timer_match_model i_tmr (.clk_i(clk_i), .arst_n_i(arst_n_i), .fire_i(fire), .lag_i(lag),
		.cmp_match_o(cm));
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	task automatic end_of_test();
		if (n_fail == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		req <= '{1'b1, 1'b0, w, {14'h0, idx, 2'b00}, {24'h0, d}};
		@(posedge clk_i);
		req.penable <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
			if (n > 40) begin
				n_fail++;
				end_of_test();
			end
		end while (rsp.pready !== 1'b1);
		q = rsp.prdata[7:0];
		e = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] idx, input logic [7:0] x);
		xfer(1'b0, idx, 8'h00);
		chk({8'h00, q}, {8'h00, x});
	endtask
	task automatic pulse(input int c);
		@(posedge clk_i);
		fire <= 4'(1 << c);
		@(posedge clk_i);
		fire <= '0;
		repeat (lag + 5) @(posedge clk_i);
	endtask
	initial begin
		req = '0;
		ce_i = 1'b1;
		fire = '0;
		lag = '0;
		arst_n_i = 1'b0;
		n_fail = 0;
		check_count = 0;
		repeat (8) @(posedge clk_i);
		arst_n_i <= 1'b1;
		rd(IDX_OUTPUT_MODE, 8'hf0);
		rd(IDX_ENABLE_UPPER, 8'h00);
		rd(IDX_DATA_UPPER, 8'h00);
		rd(IDX_DATA_LOWER, 8'h00);
		rd(16'hff45, 8'h00);
		chk({15'h0, e}, 16'h0001);
		xfer(1'b1, IDX_ENABLE_LOWER, 8'h0f);
		xfer(1'b1, IDX_DATA_LOWER, 8'hff);
		rd(IDX_DATA_LOWER, 8'hf0);
		rd(IDX_ENABLE_LOWER, 8'h0f);
		xfer(1'b1, IDX_ENABLE_UPPER, 8'hff);
		// Enable register updates on the access edge; look once it has settled
		@(negedge clk_i);
		chk(en, 16'hff0f);
		xfer(1'b1, IDX_DATA_UPPER, 8'h5a);
		rd(IDX_DATA_UPPER, 8'h00);
		// Upper store is still zero before the first load
		v = 8'h00;
		for (int c = 0; c < 4; c++) begin
			xfer(1'b1, IDX_TRIGGER_SELECT, {4{c[1:0]}});
			xfer(1'b1, IDX_NEXT_UPPER, 8'h18 << c);
			rd(IDX_NEXT_UPPER, 8'h18 << c);
			rd(IDX_NEXT_UPPER_ALT, 8'hff);
			pulse(c ^ 1);
			rd(IDX_DATA_UPPER, v);
			pulse(c);
			v = 8'h18 << c;
			rd(IDX_DATA_UPPER, v);
			chk(pins, {v, 8'hf0});
		end
		xfer(1'b1, IDX_TRIGGER_SELECT, 8'h40);
		rd(IDX_NEXT_UPPER, 8'hcf);
		rd(IDX_NEXT_UPPER_ALT, 8'hf0);
		xfer(1'b1, IDX_NEXT_UPPER, 8'h6c);
		xfer(1'b1, IDX_NEXT_UPPER_ALT, 8'h33);
		rd(IDX_NEXT_UPPER, 8'h6f);
		rd(IDX_NEXT_UPPER_ALT, 8'hf3);
		xfer(1'b1, IDX_NEXT_LOWER, 8'h5a);
		rd(IDX_NEXT_LOWER_ALT, 8'hff);
		lag <= 4'd3;
		pulse(1);
		rd(IDX_DATA_UPPER, 8'h60);
		pulse(0);
		rd(IDX_DATA_LOWER, 8'hfa);
		xfer(1'b1, IDX_OUTPUT_MODE, 8'h70);
		repeat (2) @(posedge clk_i);
		chk(pins, 16'h93fa);
		xfer(1'b1, IDX_NEXT_UPPER_ALT, 8'h0e);
		ce_i <= 1'b0;
		pulse(0);
		ce_i <= 1'b1;
		rd(IDX_DATA_UPPER, 8'h63);
		// Lower groups on different triggers: split layout at FF4D/FF4F
		xfer(1'b1, IDX_TRIGGER_SELECT, 8'h01);
		xfer(1'b1, IDX_NEXT_LOWER, 8'hc3);
		rd(IDX_NEXT_LOWER, 8'hcf);
		rd(IDX_NEXT_LOWER_ALT, 8'hfa);
		arst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		arst_n_i <= 1'b1;
		rd(IDX_ENABLE_LOWER, 8'h00);
		chk(pins, 16'h0000);
		end_of_test();
	end
endmodule
`default_nettype wire
